//--- include/dpag_defines.svh
`ifndef DPAG_DEFINES_SVH
`define DPAG_DEFINES_SVH
// ==========================================
// register map
`define DPAG_A_CTRL     16'h0000
`define DPAG_A_TRIG     16'h0004
`define DPAG_A_STAT     16'h0008
`define DPAG_EMAP_PAGE  8'h10
`define DPAG_QMAP_PAGE  12'h110
`define DPAG_RAM_PAGE   3'h2
// ==========================================
// status bits
`define DPAG_ST_BUSY    0
`define DPAG_ST_PEND    1
`define DPAG_ST_MISS    2
`define DPAG_ST_NULL    3
// ==========================================
// parameter set words
`define DPAG_W_OPT      3'h0
`define DPAG_W_SRC      3'h1
`define DPAG_W_CNT      3'h2
`define DPAG_W_DST      3'h3
`define DPAG_W_BIDX     3'h4
`define DPAG_W_LNK      3'h5
`define DPAG_W_CIDX     3'h6
`define DPAG_W_FRAMES_PER_BLOCK_COUNT     3'h7
`define DPAG_W_LAST     3'h7
`define DPAG_OPT_FSYNC  2
`define DPAG_LINK_NULL  16'hFFFF
`define DPAG_LINK_LSB   5
`define DPAG_ONE16      16'h0001
`endif

//--- include/dpag_pkg.sv
package dpag_pkg;
    typedef logic [31:0] dpag_word_t;
    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_FETCH  = 5'b00010,
        S_ISSUE  = 5'b00100,
        S_UPDATE = 5'b01000,
        S_LINK   = 5'b10000
    } dpag_state_t;
    typedef struct packed {
        dpag_state_t     st;
        logic            ena;
        logic            missed;
        logic            nullhit;
        logic            sw_pend;
        logic [6:0]      sw_chan;
        logic [6:0]      chan;
        logic [7:0]      pset;
        logic [7:0]      lset;
        logic [2:0]      lcnt;
        logic            fsync;
        logic            last;
        logic [31:0]     src;
        logic [31:0]     dst;
        logic [15:0]     array_byte_count;
        logic [15:0]     arrays_per_frame_count;
        logic [15:0]     sb;
        logic [15:0]     db;
        logic            acc;
        logic            err;
        logic [31:0]     rdata;
        logic [63:0][7:0] emap;
        logic [3:0][7:0]  qmap;
    } dpag_regs_t;
endpackage

//--- include/dpag_step_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dpag_step_if;
    logic [7:0][31:0] w;
    logic             fsync;
    logic [31:0]      nsrc;
    logic [31:0]      ndst;
    logic [31:0]      nw2;
    logic [31:0]      nw7;
    logic             done;
    logic             link_go;
    logic [7:0]       link_set;
    modport eng  (output w, fsync, input nsrc, ndst, nw2, nw7, done, link_go, link_set);
    modport calc (input w, fsync, output nsrc, ndst, nw2, nw7, done, link_go, link_set);
endinterface
`default_nettype wire

//--- verilog/dpag_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpag_defines.svh"
module dpag_step (
    dpag_step_if.calc s
);
    import dpag_pkg::*;

    function automatic logic [31:0] sx(input logic [15:0] v);
        sx = {{16{v[15]}}, v};
    endfunction

    logic [15:0] arrays_per_frame_count;
    logic [15:0] frames_per_block_count;
    logic [31:0] sstep;
    logic [31:0] dstep;

    always_comb
    begin
        arrays_per_frame_count    = s.w[`DPAG_W_CNT][31:16];
        frames_per_block_count    = s.w[`DPAG_W_FRAMES_PER_BLOCK_COUNT][15:0];
        sstep   = sx(s.w[`DPAG_W_CIDX][15:0]);
        dstep   = sx(s.w[`DPAG_W_CIDX][31:16]);
        s.nw2   = s.w[`DPAG_W_CNT];
        s.nw7   = s.w[`DPAG_W_FRAMES_PER_BLOCK_COUNT];
        s.done  = 1'b0;
        if (!s.fsync && arrays_per_frame_count > `DPAG_ONE16)
        begin
            sstep = sx(s.w[`DPAG_W_BIDX][15:0]);
            dstep = sx(s.w[`DPAG_W_BIDX][31:16]);
            s.nw2[31:16] = arrays_per_frame_count - `DPAG_ONE16;
        end
        else
        begin
            // last array of a frame reloads the array count
            if (!s.fsync)
                s.nw2[31:16] = s.w[`DPAG_W_LNK][31:16];
            s.nw7[15:0] = frames_per_block_count - `DPAG_ONE16;
            s.done = frames_per_block_count <= `DPAG_ONE16;
        end
        s.nsrc     = s.w[`DPAG_W_SRC] + sstep;
        s.ndst     = s.w[`DPAG_W_DST] + dstep;
        s.link_go  = s.w[`DPAG_W_LNK][15:0] != `DPAG_LINK_NULL;
        s.link_set = s.w[`DPAG_W_LNK][`DPAG_LINK_LSB +: 8];
    end
endmodule
`default_nettype wire

//--- verilog/dpag_engine.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dpag_defines.svh"
module dpag_engine (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [15:0]        paddr,
    input  wire dpag_pkg::dpag_word_t pwdata,
    output var  dpag_pkg::dpag_word_t prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               evt_req,
    input  wire logic [5:0]         evt_chan,
    output logic                    evt_ready,
    output logic                    tr_valid,
    input  wire logic               tr_ready,
    output logic [6:0]              tr_chan,
    output var  dpag_pkg::dpag_word_t tr_src,
    output var  dpag_pkg::dpag_word_t tr_dst,
    output logic [15:0]             tr_array_byte_count,
    output logic [15:0]             tr_arrays_per_frame_count,
    output logic [15:0]             tr_source_frame_dim_index_alt,
    output logic [15:0]             tr_dest_frame_dim_index_alt,
    output logic                    tr_fsync,
    output logic                    tr_last
);
    import dpag_pkg::*;

    // ==========================================
    // storage
    dpag_word_t  ram [0:2047];
    dpag_regs_t  q;
    dpag_regs_t  d;
    dpag_word_t  cw [0:7];
    dpag_word_t  rd_val;
    logic        hit;
    logic        ram_sel;
    logic        emap_sel;
    logic        qmap_sel;
    logic        busy;
    logic        acc_go;
    dpag_step_if sif ();

    dpag_step u_step (
        .s (sif.calc)
    );

    // live view of the selected set
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_word
            assign cw[gi]    = ram[{q.pset, 3'(gi)}];
            assign sif.w[gi] = cw[gi];
        end
    endgenerate
    assign sif.fsync = cw[`DPAG_W_OPT][`DPAG_OPT_FSYNC];

    // ==========================================
    // bus decode
    assign ram_sel  = paddr[15:13] == `DPAG_RAM_PAGE;
    assign emap_sel = paddr[15:8] == `DPAG_EMAP_PAGE;
    assign qmap_sel = paddr[15:4] == `DPAG_QMAP_PAGE;
    assign busy     = q.st != S_IDLE;
    // ram held off while the engine owns it; avoids torn sets
    assign acc_go   = psel && penable && !q.acc && !(ram_sel && busy);
    assign pready   = psel && penable && q.acc;
    assign pslverr  = pready && q.err;
    assign prdata   = q.rdata;

    always_comb
    begin
        rd_val = '0;
        hit    = 1'b1;
        if (ram_sel)
            rd_val = ram[paddr[12:2]];
        else if (emap_sel)
            rd_val = {24'h000000, q.emap[paddr[7:2]]};
        else if (qmap_sel)
            rd_val = {24'h000000, q.qmap[paddr[3:2]]};
        else if (paddr == `DPAG_A_CTRL)
            rd_val = {31'h0, q.ena};
        else if (paddr == `DPAG_A_TRIG)
            rd_val = {25'h0, q.sw_chan};
        else if (paddr == `DPAG_A_STAT)
            rd_val = {28'h0000000, q.nullhit, q.missed, q.sw_pend, busy};
        else
            hit = 1'b0;
    end

    // ==========================================
    // handshakes and request fields
    assign evt_ready = q.st == S_IDLE && q.ena;
    assign tr_valid  = q.st == S_ISSUE;
    assign tr_chan   = q.chan;
    assign tr_src    = q.src;
    assign tr_dst    = q.dst;
    assign tr_array_byte_count   = q.array_byte_count;
    assign tr_arrays_per_frame_count   = q.arrays_per_frame_count;
    assign tr_source_frame_dim_index_alt  = q.sb;
    assign tr_dest_frame_dim_index_alt  = q.db;
    assign tr_fsync  = q.fsync;
    assign tr_last   = q.last;

    // ==========================================
    // next state
    always_comb
    begin
        d = q;
        if (acc_go)
        begin
            d.acc   = 1'b1;
            d.rdata = rd_val;
            d.err   = !hit;
        end
        if (pready)
        begin
            d.acc = 1'b0;
            if (pwrite && !q.err)
            begin
                if (emap_sel)
                    d.emap[paddr[7:2]] = pwdata[7:0];
                else if (qmap_sel)
                    d.qmap[paddr[3:2]] = pwdata[7:0];
                else if (paddr == `DPAG_A_CTRL)
                    d.ena = pwdata[0];
                else if (paddr == `DPAG_A_STAT)
                begin
                    if (pwdata[`DPAG_ST_MISS])
                        d.missed = 1'b0;
                    if (pwdata[`DPAG_ST_NULL])
                        d.nullhit = 1'b0;
                end
                else if (paddr == `DPAG_A_TRIG)
                begin
                    // one pending software trigger; extra ones are flagged
                    if (q.sw_pend)
                        d.missed = 1'b1;
                    else
                    begin
                        d.sw_pend = 1'b1;
                        d.sw_chan = pwdata[6:0];
                    end
                end
            end
        end
        unique case (q.st)
            S_IDLE:
            begin
                if (evt_req && evt_ready)
                begin
                    d.chan = {1'b0, evt_chan};
                    d.pset = q.emap[evt_chan];
                    d.st   = S_FETCH;
                end
                else if (q.sw_pend && q.ena)
                begin
                    d.sw_pend = 1'b0;
                    d.chan    = q.sw_chan;
                    d.pset    = q.sw_chan[6] ? q.qmap[q.sw_chan[1:0]]
                                             : q.emap[q.sw_chan[5:0]];
                    d.st      = S_FETCH;
                end
            end
            S_FETCH:
            begin
                // an exhausted or empty set raises no request
                if (cw[`DPAG_W_FRAMES_PER_BLOCK_COUNT][15:0] == 16'h0000 ||
                    cw[`DPAG_W_CNT][31:16] == 16'h0000)
                begin
                    d.nullhit = 1'b1;
                    d.st      = S_IDLE;
                end
                else
                begin
                    d.src   = cw[`DPAG_W_SRC];
                    d.dst   = cw[`DPAG_W_DST];
                    d.array_byte_count  = cw[`DPAG_W_CNT][15:0];
                    d.fsync = sif.fsync;
                    d.arrays_per_frame_count  = sif.fsync ? cw[`DPAG_W_CNT][31:16]
                                        : `DPAG_ONE16;
                    d.sb    = cw[`DPAG_W_BIDX][15:0];
                    d.db    = cw[`DPAG_W_BIDX][31:16];
                    d.last  = sif.done;
                    d.st    = S_ISSUE;
                end
            end
            S_ISSUE:
            begin
                if (tr_ready)
                    d.st = S_UPDATE;
            end
            S_UPDATE:
            begin
                d.lset = sif.link_set;
                d.lcnt = 3'h0;
                d.st   = (sif.done && sif.link_go) ? S_LINK : S_IDLE;
            end
            S_LINK:
            begin
                d.lcnt = q.lcnt + 3'h1;
                if (q.lcnt == `DPAG_W_LAST)
                    d.st = S_IDLE;
            end
            default:
                d.st = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q    <= '0;
            q.st <= S_IDLE;
        end
        else
            q <= d;
    end

    // ==========================================
    // parameter ram writes
    always_ff @(posedge pclk)
    begin
        if (q.st == S_UPDATE)
        begin
            ram[{q.pset, `DPAG_W_SRC}]  <= sif.nsrc;
            ram[{q.pset, `DPAG_W_DST}]  <= sif.ndst;
            ram[{q.pset, `DPAG_W_CNT}]  <= sif.nw2;
            ram[{q.pset, `DPAG_W_FRAMES_PER_BLOCK_COUNT}] <= sif.nw7;
        end
        else if (q.st == S_LINK)
            ram[{q.pset, q.lcnt}] <= ram[{q.lset, q.lcnt}];
        else if (pready && pwrite && ram_sel)
            ram[paddr[12:2]] <= pwdata;
    end

    // ==========================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_one_array;
        tr_valid && !tr_fsync |-> tr_arrays_per_frame_count == `DPAG_ONE16;
    endproperty
    a_one_array: assert property (p_one_array)
        else $error("array-sync request not one array");

    property p_whole_frame;
        tr_valid && tr_fsync |-> tr_arrays_per_frame_count == cw[`DPAG_W_CNT][31:16];
    endproperty
    a_whole_frame: assert property (p_whole_frame)
        else $error("frame-sync request not whole frame");

    property p_wb_after;
        q.st == S_UPDATE |-> $past(tr_valid) && $past(tr_ready);
    endproperty
    a_wb_after: assert property (p_wb_after)
        else $error("write-back without request handoff");

    property p_astep;
        q.st == S_UPDATE && !q.fsync && cw[`DPAG_W_CNT][31:16] > `DPAG_ONE16
        |=> cw[`DPAG_W_SRC] == $past(q.src) + {{16{$past(q.sb[15])}}, $past(q.sb)};
    endproperty
    a_astep: assert property (p_astep)
        else $error("array source step wrong");

    property p_fstep;
        q.st == S_UPDATE && q.fsync |=> cw[`DPAG_W_DST] == $past(q.dst)
            + {{16{$past(cw[`DPAG_W_CIDX][31])}}, $past(cw[`DPAG_W_CIDX][31:16])};
    endproperty
    a_fstep: assert property (p_fstep)
        else $error("frame destination step wrong");

    property p_reload;
        q.st == S_UPDATE && !q.fsync && cw[`DPAG_W_CNT][31:16] == `DPAG_ONE16
        |=> cw[`DPAG_W_CNT][31:16] == $past(cw[`DPAG_W_LNK][31:16])
            && cw[`DPAG_W_FRAMES_PER_BLOCK_COUNT][15:0] == $past(cw[`DPAG_W_FRAMES_PER_BLOCK_COUNT][15:0]) - `DPAG_ONE16;
    endproperty
    a_reload: assert property (p_reload)
        else $error("array count reload wrong");

    property p_null_end;
        q.st == S_UPDATE && sif.done && !sif.link_go |=> q.st == S_IDLE;
    endproperty
    a_null_end: assert property (p_null_end)
        else $error("reload after end of chain");

    property p_link_copy;
        q.st == S_UPDATE && sif.done && sif.link_go
        |=> (q.st == S_LINK) [*8] ##1 q.st == S_IDLE;
    endproperty
    a_link_copy: assert property (p_link_copy)
        else $error("link reload not eight words");

    property p_map;
        evt_req && evt_ready |=> q.st == S_FETCH && q.pset == $past(q.emap[evt_chan]);
    endproperty
    a_map: assert property (p_map)
        else $error("event mapped to wrong set");

    property p_live;
        q.st == S_FETCH && cw[`DPAG_W_FRAMES_PER_BLOCK_COUNT][15:0] != 16'h0000
            && cw[`DPAG_W_CNT][31:16] != 16'h0000 |=> tr_valid;
    endproperty
    a_live: assert property (p_live)
        else $error("live set raised no request");
endmodule
`default_nettype wire

//--- verif/dpag_tc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// transfer controller stand-in
module dpag_tc_model (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [3:0]           stall,
    input  wire logic                 tr_valid,
    input  wire logic [6:0]           tr_chan,
    input  wire dpag_pkg::dpag_word_t tr_src,
    input  wire dpag_pkg::dpag_word_t tr_dst,
    input  wire logic [15:0]          tr_array_byte_count,
    input  wire logic [15:0]          tr_arrays_per_frame_count,
    input  wire logic [15:0]          tr_source_frame_dim_index_alt,
    input  wire logic [15:0]          tr_dest_frame_dim_index_alt,
    input  wire logic                 tr_fsync,
    input  wire logic                 tr_last,
    output var logic                  tr_ready,
    output var logic [136:0]          cap,
    output var logic [7:0]            n_acc
);
    import dpag_pkg::*;
    logic [3:0] cnt;
    // a slow accept proves the engine holds its offer until taken
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tr_ready <= 1'b0;
            cnt      <= 4'h0;
            n_acc    <= 8'h00;
            cap      <= '0;
        end
        else if (tr_valid && tr_ready)
        begin
            cap      <= {tr_chan, tr_src, tr_dst, tr_array_byte_count, tr_arrays_per_frame_count,
                         tr_source_frame_dim_index_alt, tr_dest_frame_dim_index_alt, tr_fsync, tr_last};
            n_acc    <= n_acc + 8'h01;
            tr_ready <= 1'b0;
            cnt      <= 4'h0;
        end
        else if (tr_valid && cnt >= stall)
            tr_ready <= 1'b1;
        else if (tr_valid)
            cnt <= cnt + 4'h1;
    end
endmodule
`default_nettype wire

//--- verif/dpag_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dpag_engine_bench;
    import dpag_pkg::*;
    // ==========================================
    // signals
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [15:0]  paddr;
    dpag_word_t   pwdata;
    dpag_word_t   prdata;
    logic         pready;
    logic         pslverr;
    logic         evt_req;
    logic [5:0]   evt_chan;
    logic         evt_ready;
    logic         tr_valid;
    logic         tr_ready;
    logic [6:0]   tr_chan;
    dpag_word_t   tr_src;
    dpag_word_t   tr_dst;
    logic [15:0]  tr_array_byte_count;
    logic [15:0]  tr_arrays_per_frame_count;
    logic [15:0]  tr_source_frame_dim_index_alt;
    logic [15:0]  tr_dest_frame_dim_index_alt;
    logic         tr_fsync;
    logic         tr_last;
    logic [3:0]   stall;
    logic [136:0] cap;
    logic [7:0]   n_acc;
    int           errors;
    int           samples_checked;
    dpag_word_t   q;
    logic         e;

    dpag_engine dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_req(evt_req), .evt_chan(evt_chan), .evt_ready(evt_ready),
        .tr_valid(tr_valid), .tr_ready(tr_ready), .tr_chan(tr_chan), .tr_src(tr_src),
        .tr_dst(tr_dst), .tr_array_byte_count(tr_array_byte_count), .tr_arrays_per_frame_count(tr_arrays_per_frame_count), .tr_source_frame_dim_index_alt(tr_source_frame_dim_index_alt),
        .tr_dest_frame_dim_index_alt(tr_dest_frame_dim_index_alt), .tr_fsync(tr_fsync), .tr_last(tr_last)
    );
    dpag_tc_model tc (
        .pclk(pclk), .presetn(presetn), .stall(stall), .tr_valid(tr_valid),
        .tr_chan(tr_chan), .tr_src(tr_src), .tr_dst(tr_dst), .tr_array_byte_count(tr_array_byte_count),
        .tr_arrays_per_frame_count(tr_arrays_per_frame_count), .tr_source_frame_dim_index_alt(tr_source_frame_dim_index_alt), .tr_dest_frame_dim_index_alt(tr_dest_frame_dim_index_alt),
        .tr_fsync(tr_fsync), .tr_last(tr_last), .tr_ready(tr_ready), .cap(cap), .n_acc(n_acc)
    );

    always #2 pclk = ~pclk;

    // ==========================================
    // helpers
    task automatic chk(input logic [136:0] seen, input logic [136:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [136:0] pk(input logic [6:0] c, input dpag_word_t s,
        input dpag_word_t d, input logic [15:0] a, input logic [15:0] b,
        input logic [15:0] si, input logic [15:0] di, input logic f, input logic l);
        return {c, s, d, a, b, si, di, f, l};
    endfunction

    // the extra edge after release keeps back-to-back calls from double driving
    task automatic apb(input logic wr, input logic [15:0] a, input dpag_word_t d,
        output dpag_word_t rq, output logic re);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 500 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (n >= 500)
            errors++;
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] a, input dpag_word_t d);
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [15:0] a, input dpag_word_t exp);
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
    endtask

    task automatic wset(input logic [7:0] s, input dpag_word_t v [8]);
        for (int w = 0; w < 8; w++)
            wr(16'h4000 | {3'h0, s, w[2:0], 2'h0}, v[w]);
    endtask

    task automatic evt(input logic [5:0] c);
        int n;
        evt_req  <= 1'b1;
        evt_chan <= c;
        @(posedge pclk);
        for (n = 0; n < 500 && evt_ready !== 1'b1; n++)
            @(posedge pclk);
        if (n >= 500)
            errors++;
        evt_req <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_acc(input logic [7:0] k);
        for (int n = 0; n < 500 && n_acc !== k; n++)
            @(posedge pclk);
        chk(n_acc, k);
    endtask

    task automatic idle();
        int n;
        @(posedge pclk);
        for (n = 0; n < 500 && evt_ready !== 1'b1; n++)
            @(posedge pclk);
        if (n >= 500)
            errors++;
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // tests
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        evt_req = 1'b0;
        evt_chan = 6'h00;
        stall = 4'h0;
        errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(16'h0000, 32'h0000_0000);
        rd(16'h1000, 32'h0000_0000);
        apb(1'b1, 16'h2000, 32'hFFFF_FFFF, q, e);
        chk(e, 1'b1);
        apb(1'b0, 16'h2000, 32'h0000_0000, q, e);
        chk({e, q}, {1'b1, 32'h0000_0000});
        wr(16'h10FC, 32'h0000_00FF);
        rd(16'h10FC, 32'h0000_00FF);
        wr(16'h110C, 32'h0000_0080);
        rd(16'h110C, 32'h0000_0080);
        wr(16'h100C, 32'h0000_0005);
        wr(16'h1104, 32'h0000_0009);
        // last set of each chain carries the all-ones link
        wset(8'h05, '{32'h0, 32'hA000_1000, 32'h0002_0010, 32'h5000_2000,
            32'h0008_0004, 32'h0002_FFFF, 32'h0200_0100, 32'h0000_0002});
        wset(8'h09, '{32'h4, 32'h3000, 32'h0003_0008, 32'h4000,
            32'h0020_0010, 32'h0000_0180, 32'h0080_0100, 32'h0000_0002});
        wset(8'h0C, '{32'h4, 32'h7000, 32'h0001_0004, 32'h7800,
            32'h0, 32'h0000_FFFF, 32'h0, 32'h0000_0001});
        rd(16'h419C, 32'h0000_0001);
        // triggers while disabled: second one is recorded as missed
        wr(16'h0004, 32'h0000_0041);
        wr(16'h0004, 32'h0000_0041);
        rd(16'h0008, 32'h0000_0006);
        wr(16'h0008, 32'h0000_0004);
        rd(16'h0008, 32'h0000_0002);
        stall <= 4'h3;
        wr(16'h0000, 32'h0000_0001);
        wait_acc(8'h01);
        chk(cap, pk(7'h41, 32'h3000, 32'h4000, 16'h8, 16'h3, 16'h10, 16'h20, 1, 0));
        wr(16'h0004, 32'h0000_0041);
        wait_acc(8'h02);
        chk(cap, pk(7'h41, 32'h3100, 32'h4080, 16'h8, 16'h3, 16'h10, 16'h20, 1, 1));
        rd(16'h4124, 32'h0000_7000);
        wr(16'h0004, 32'h0000_0041);
        wait_acc(8'h03);
        chk(cap, pk(7'h41, 32'h7000, 32'h7800, 16'h4, 16'h1, 16'h0, 16'h0, 1, 1));
        wr(16'h0004, 32'h0000_0041);
        idle();
        rd(16'h0008, 32'h0000_0008);
        wr(16'h0008, 32'h0000_0008);
        rd(16'h0008, 32'h0000_0000);
        stall <= 4'h0;
        evt(6'h03);
        wait_acc(8'h04);
        chk(cap, pk(7'h03, 32'hA000_1000, 32'h5000_2000, 16'h10, 16'h1, 16'h4, 16'h8, 0, 0));
        rd(16'h40A8, 32'h0001_0010);
        evt(6'h03);
        wait_acc(8'h05);
        chk(cap, pk(7'h03, 32'hA000_1004, 32'h5000_2008, 16'h10, 16'h1, 16'h4, 16'h8, 0, 0));
        rd(16'h40A8, 32'h0002_0010);
        rd(16'h40BC, 32'h0000_0001);
        evt(6'h03);
        evt(6'h03);
        wait_acc(8'h07);
        chk(cap[0], 1'b1);
        evt(6'h03);
        idle();
        rd(16'h0008, 32'h0000_0008);
        chk(n_acc, 8'h07);
        wrap_up();
    end

    // whole run is a few hundred cycles; this is far beyond it
    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
